// >>> design/msis_sequencer.sv
/*
  Device end: input sequencer. Tracks init and block sequences, captures
  pixels on the four ports, and reports sequence boundaries and the
  result hand-off of each finished block sequence. The state trails the
  link by one cycle, so link pixels pass one holding stage first.
  Assumes the link is driven synchronously to ref_clk, and that a strobe
  only comes in the first cycle of a sequence.
*/
module msis_sequencer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // link
  msis_link_if.dev         link,
  // configuration: block width in groups of four columns
  input  wire logic [3:0]  width_quads,
  // user side
  output logic             seq_init_r,
  output logic             seq_block_r,
  output logic             pix_valid_r,
  output logic [7:0]       ref_pix_r,
  output logic [7:0]       win_a_r,
  output logic [7:0]       win_b_r,
  output logic [7:0]       win_c_r,
  output logic             tall_r,
  output logic             rect_r,
  output logic             block_done_r,
  output logic             sync_error_r
);
  msis_pkg::msis_state_e state_r;
  msis_pkg::msis_state_e state_nxt;
  logic [11:0]             cnt_r;
  logic [11:0]             len_r;
  logic [11:0]             len_nxt;
  logic                    strobe;
  logic                    last;
  logic                    tall_nxt;
  logic                    rect_nxt;
  logic [3:0]              nq;
  logic                    in_idle;
  logic                    in_init;
  logic                    in_block;
  logic                    seq_end;
  logic                    blk_end;
  logic                    cnt_clr;
  logic                    win_open;
  logic                    sync_missing;
  logic                    sync_stray;
  // link pixels held one cycle to line up with the state
  logic [7:0]              ref_d_r;
  logic [7:0]              win_a_d_r;
  logic [7:0]              win_b_d_r;
  logic [7:0]              win_c_d_r;

  assign strobe = !link.block_sync_strobe_n;
  assign last   = (cnt_r == len_r - 12'h0001);
  assign nq     = (width_quads == 4'h0) ? msis_pkg::NQ_DEFAULT : width_quads;
  // selects taken at every strobe
  assign tall_nxt = strobe ? link.height_select : tall_r;
  assign rect_nxt = strobe ? link.square_block_select_n : rect_r;

  // state decode shared by several concerns
  assign in_idle  = (state_r == msis_pkg::MSIS_IDLE);
  assign in_init  = (state_r == msis_pkg::MSIS_INIT);
  assign in_block = (state_r == msis_pkg::MSIS_BLOCK);
  assign seq_end  = !in_idle && last;
  assign blk_end  = in_block && last;
  assign cnt_clr  = (state_r != state_nxt) || blk_end;
  // window ports idle for the first H cycles of init
  assign win_open = in_block || (in_init && cnt_r >= msis_pkg::msis_idle_len(tall_r));
  // every block, the first one too, needs its strobe when rectangular
  assign sync_missing = seq_end && rect_r && !strobe;
  // strobe off a boundary breaks the pipeline
  assign sync_stray   = strobe && !in_idle && !last;

  always_comb begin
    state_nxt = state_r;
    len_nxt   = len_r;
    case (state_r)
      msis_pkg::MSIS_IDLE: begin
        if (strobe) begin // strobe readies the device
          state_nxt = msis_pkg::MSIS_INIT;
          len_nxt   = msis_pkg::msis_init_len(tall_nxt);
        end
      end
      msis_pkg::MSIS_INIT: begin
        if (last) begin // init always followed by block
          state_nxt = msis_pkg::MSIS_BLOCK;
          len_nxt   = msis_pkg::msis_block_len(tall_nxt, nq);
        end
      end
      msis_pkg::MSIS_BLOCK: begin
        // continuous mode: block after block, no gap
        if (last) begin
          len_nxt = msis_pkg::msis_block_len(tall_nxt, nq); // area count
        end
      end
      default: begin
        state_nxt = msis_pkg::MSIS_IDLE;
      end
    endcase
  end

  // sequencer state and current sequence length
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= msis_pkg::MSIS_IDLE;
      len_r   <= msis_pkg::INIT_LEN_8;
    end else begin
      state_r <= state_nxt;
      len_r   <= len_nxt;
    end
  end

  // cycles into the current sequence
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_r <= 12'h0000;
    end else if (cnt_clr) begin
      cnt_r <= 12'h0000;
    end else if (!in_idle) begin
      cnt_r <= cnt_r + 12'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tall_r <= 1'b0;
    end else begin
      tall_r <= tall_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rect_r <= 1'b0;
    end else begin
      rect_r <= rect_nxt;
    end
  end

  // strobe must match sequence boundaries
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync_error_r <= 1'b0;
    end else begin
      sync_error_r <= sync_missing || sync_stray;
    end
  end

  // holding stage: pixel of link cycle c meets the state of cycle c
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_d_r   <= 8'h00;
      win_a_d_r <= 8'h00;
      win_b_d_r <= 8'h00;
      win_c_d_r <= 8'h00;
    end else begin
      ref_d_r   <= link.ref_pix;
      win_a_d_r <= link.win_a_pix;
      win_b_d_r <= link.win_b_pix;
      win_c_d_r <= link.win_c_pix;
    end
  end

  // sequence indicators
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      seq_init_r  <= 1'b0;
      seq_block_r <= 1'b0;
    end else begin
      seq_init_r  <= in_init;
      seq_block_r <= in_block;
    end
  end

  // pixels valid in block sequences and in init past its idle stretch
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pix_valid_r <= 1'b0;
    end else begin
      pix_valid_r <= win_open;
    end
  end

  // reference block only loads during block sequences
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ref_pix_r <= 8'h00;
    end else begin
      ref_pix_r <= in_block ? ref_d_r : 8'h00;
    end
  end

  // window ports, every cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      win_a_r <= 8'h00;
      win_b_r <= 8'h00;
      win_c_r <= 8'h00;
    end else begin
      win_a_r <= win_a_d_r;
      win_b_r <= win_b_d_r;
      win_c_r <= win_c_d_r;
    end
  end

  // results of block k handed on as block k+1 loads
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      block_done_r <= 1'b0;
    end else begin
      block_done_r <= blk_end;
    end
  end
endmodule

// >>> design/msis_pkg.sv
/*
  Constants and types shared by both ends of the pixel input link:
  sequence lengths, port widths and sequencer states.
  Assumes one clock (ref_clk, 125 MHz) and a synchronous active-high reset.
*/
// Notes on behaviour
// - init sequence starts with strobe low
// - 8-high init: 8 idle, 128 total
// - 16-high init: 16 idle, 256 total
// - rectangular blocks need strobe per block
// - 8-high block sequence lasts 32n cycles
// - 16-high block sequence lasts 64n cycles
// - filler pixels keep sub-window loads equal
// - first and third window ports may tie
// - sequences follow with no idle cycle
// - init then block; block computes distortions
// - continuous mode needs 15-column overlap
// - previous results available during next block
// - pipeline kept at right frame edge
// - height and square selects sampled at strobe
// - one pixel per clock, column-major order
// - heights 8 or 16, width multiple four
package msis_pkg;
  localparam int unsigned PIX_W        = 8;
  localparam int unsigned CNT_W        = 12;
  localparam int unsigned NQ_W         = 4;
  localparam logic [11:0] INIT_LEN_8   = 12'h0080;
  localparam logic [11:0] INIT_LEN_16  = 12'h0100;
  localparam logic [11:0] IDLE_LEN_8   = 12'h0008;
  localparam logic [11:0] IDLE_LEN_16  = 12'h0010;
  localparam logic [11:0] QUAD_LEN_8   = 12'h0020;
  localparam logic [11:0] QUAD_LEN_16  = 12'h0040;
  localparam logic [3:0]  NQ_DEFAULT   = 4'h1;

  typedef enum logic [1:0] {
    MSIS_IDLE  = 2'b00,
    MSIS_INIT  = 2'b01,
    MSIS_BLOCK = 2'b10
  } msis_state_e;

  // sequence length from height and block width in groups of four columns
  function automatic logic [11:0] msis_block_len(input logic tall, input logic [3:0] nq);
    logic [11:0] unit;
    unit = tall ? QUAD_LEN_16 : QUAD_LEN_8;
    msis_block_len = 12'(unit * nq);
  endfunction

  function automatic logic [11:0] msis_init_len(input logic tall);
    msis_init_len = tall ? INIT_LEN_16 : INIT_LEN_8;
  endfunction

  function automatic logic [11:0] msis_idle_len(input logic tall);
    msis_idle_len = tall ? IDLE_LEN_16 : IDLE_LEN_8;
  endfunction
endpackage

// >>> design/msis_link_if.sv
/*
  Pixel input link between the system controller and the sequencer.
  Assumes both ends run on the same ref_clk.
*/
interface msis_link_if;
  logic [7:0] ref_pix;
  logic [7:0] win_a_pix;
  logic [7:0] win_b_pix;
  logic [7:0] win_c_pix;
  logic       block_sync_strobe_n;
  logic       height_select;
  logic       square_block_select_n;

  modport ctrl (
    output ref_pix, win_a_pix, win_b_pix, win_c_pix,
    output block_sync_strobe_n, height_select, square_block_select_n
  );
  modport dev (
    input ref_pix, win_a_pix, win_b_pix, win_c_pix,
    input block_sync_strobe_n, height_select, square_block_select_n
  );
endinterface

// >>> design/msis_controller.sv
/*
  System end: drives pixel ports and the block sync strobe from a user
  pixel stream. Starts with one init sequence then block sequences.
  Assumes the user stream supplies a pixel set every cycle once started.
*/
module msis_controller (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // link
  msis_link_if.ctrl        link,
  // user side
  input  wire logic        start,
  input  wire logic        tall,
  input  wire logic        rect,
  input  wire logic [3:0]  width_quads,
  input  wire logic [7:0]  u_ref,
  input  wire logic [7:0]  u_a,
  input  wire logic [7:0]  u_b,
  input  wire logic [7:0]  u_c,
  input  wire logic        tie_ac,
  output logic             busy_r
);
  logic [11:0] cnt_r;
  logic [11:0] len_r;
  logic        last;
  logic [3:0]  nq;

  assign last = (cnt_r == len_r - 12'h0001);
  assign nq   = (width_quads == 4'h0) ? msis_pkg::NQ_DEFAULT : width_quads;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_r     <= 1'b0;
      cnt_r      <= 12'h0000;
      len_r      <= msis_pkg::INIT_LEN_8;
    end else if (!busy_r) begin
      if (start) begin
        busy_r <= 1'b1;
        cnt_r  <= 12'h0000;
        len_r  <= msis_pkg::msis_init_len(tall);
      end
    end else if (last) begin
      cnt_r      <= 12'h0000; // back to back, no gap
      len_r      <= msis_pkg::msis_block_len(tall, nq);
    end else begin
      cnt_r <= cnt_r + 12'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      link.block_sync_strobe_n   <= 1'b1;
      link.height_select         <= 1'b0;
      link.square_block_select_n <= 1'b0;
      link.ref_pix               <= 8'h00;
      link.win_a_pix             <= 8'h00;
      link.win_b_pix             <= 8'h00;
      link.win_c_pix             <= 8'h00;
    end else begin
      link.height_select         <= tall;
      link.square_block_select_n <= rect;
      // strobe first cycle of init, and of each block if rectangular
      link.block_sync_strobe_n <= !((!busy_r && start) || (busy_r && last && rect));
      link.ref_pix   <= u_ref;
      link.win_a_pix <= tie_ac ? u_c : u_a; // u_c filler driven only when tie_ac
      link.win_b_pix <= u_b;
      link.win_c_pix <= u_c;
    end
  end
endmodule

// >>> verification/msis_link_chk.sv
/*
  Checker for the pixel link: strobe shape, select hold, sequence lengths.
  Assumes one clock and the link signals wired in by name.
*/
module msis_link_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // link
  input wire logic block_sync_strobe_n,
  input wire logic height_select,
  input wire logic square_block_select_n
);
  logic [11:0] cnt_r;
  logic [1:0]  ph_r;
  logic        h_r;
  logic        q_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // cycles since the last strobe
  always_ff @(posedge ref_clk) begin
    if (srst) cnt_r <= 12'h0000;
    else if (!block_sync_strobe_n) cnt_r <= 12'h0001;
    else if (cnt_r != 12'hfff) cnt_r <= cnt_r + 12'h001;
  end

  // 1 = in init, 2 = in blocks; selects seen at the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) ph_r <= 2'b00;
    else if (!block_sync_strobe_n) ph_r <= (ph_r == 2'b00) ? 2'b01 : 2'b10;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) {h_r, q_r} <= 2'b00;
    else if (!block_sync_strobe_n) {h_r, q_r} <= {height_select, square_block_select_n};
  end

  sequence s_sync;
    !block_sync_strobe_n;
  endsequence
  sequence s_rect_at(logic [1:0] ph, logic h);
    s_sync ##0 (ph_r == ph && q_r && h_r == h);
  endsequence

  AST_SYNC_PULSE: assert property (s_sync |=> block_sync_strobe_n)
    else $error("strobe held longer than one cycle");
  AST_SEL_HOLD: assert property (block_sync_strobe_n |-> $stable(height_select) && $stable(square_block_select_n))
    else $error("select changed without strobe");
  AST_INIT_LEN_8: assert property (s_rect_at(2'b01, 1'b0) |-> cnt_r == 12'h080)
    else $error("8-high init length wrong");
  AST_INIT_LEN_16: assert property (s_rect_at(2'b01, 1'b1) |-> cnt_r == 12'h100)
    else $error("16-high init length wrong");
  AST_INIT_BOUND: assert property (ph_r == 2'b01 && q_r |-> cnt_r <= (h_r ? 12'h100 : 12'h080))
    else $error("block strobe overdue after init");
  AST_BLK_LEN_8: assert property (s_rect_at(2'b10, 1'b0) |-> cnt_r[4:0] == 5'h00 && cnt_r inside {[12'h020:12'h1e0]})
    else $error("8-high block length wrong");
  AST_BLK_LEN_16: assert property (s_rect_at(2'b10, 1'b1) |-> cnt_r[5:0] == 6'h00 && cnt_r inside {[12'h040:12'h3c0]})
    else $error("16-high block length wrong");
  AST_BLK_BOUND: assert property (ph_r == 2'b10 && q_r |-> cnt_r <= (h_r ? 12'h3c0 : 12'h1e0))
    else $error("rectangular block strobe missing");
endmodule

// >>> verification/motion_search_input_sequencer_tb.sv
/*
  Bench: controller drives the link into the sequencer; user sides checked.
  Assumes package, interface and both ends compiled first.
*/
module motion_search_input_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       start = 1'b0;
  logic       tall = 1'b0;
  logic       rect = 1'b0;
  logic       tie_ac = 1'b0;
  logic [3:0] nq = 4'h1;
  logic [7:0] u_ref;
  logic [7:0] u_a = 8'h11;
  logic [7:0] u_b = 8'h96;
  logic [7:0] u_c = 8'ha5;
  logic       busy, s_init, s_blk, pv, t_r, r_r, done, serr, se;
  logic [7:0] p_ref, p_a, p_b, p_c;
  int         err_count = 0;
  int         comparisons = 0;
  int         cyc = 0;

  always #4 ref_clk = ~ref_clk;
  // ref pixel steps once per link cycle after start, so link cycle j carries 3c+j (j = 0 at the strobe)
  always @(negedge ref_clk) u_ref <= busy ? u_ref + 8'h01 : 8'h3c;
  always @(posedge ref_clk) se <= srst ? 1'b0 : (se | (serr === 1'b1));
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      final_report();
    end
  end

  msis_link_if i_msis_link_if ();
  msis_controller i_msis_controller (.ref_clk(ref_clk), .srst(srst), .link(i_msis_link_if), .start(start),
    .tall(tall), .rect(rect), .width_quads(nq), .u_ref(u_ref), .u_a(u_a), .u_b(u_b), .u_c(u_c),
    .tie_ac(tie_ac), .busy_r(busy));
  msis_sequencer i_msis_sequencer (.ref_clk(ref_clk), .srst(srst), .link(i_msis_link_if), .width_quads(nq),
    .seq_init_r(s_init), .seq_block_r(s_blk), .pix_valid_r(pv), .ref_pix_r(p_ref), .win_a_r(p_a),
    .win_b_r(p_b), .win_c_r(p_c), .tall_r(t_r), .rect_r(r_r), .block_done_r(done), .sync_error_r(serr));
  msis_link_chk i_msis_link_chk (.ref_clk(ref_clk), .srst(srst),
    .block_sync_strobe_n(i_msis_link_if.block_sync_strobe_n), .height_select(i_msis_link_if.height_select),
    .square_block_select_n(i_msis_link_if.square_block_select_n));

  task automatic cmp_n(input string what, input int exp, input int got);
    comparisons++;
    if (exp != got) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cmp_v(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (exp !== got) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // reset, start, then measure init, idle, block spacing and pixel path
  task automatic run_case(input logic t, input logic r, input logic [3:0] n, input logic ti);
    int k;
    int p;
    int blen;
    tall = t;
    rect = r;
    nq = n;
    tie_ac = ti;
    srst = 1'b1;
    repeat (16) @(negedge ref_clk);
    srst = 1'b0;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    cmp_v("strobe", 8'h00, {7'h00, i_msis_link_if.block_sync_strobe_n});
    cmp_v("height", {7'h00, t}, {7'h00, i_msis_link_if.height_select});
    k = 0;
    while (s_init !== 1'b1 && k < 9) begin
      @(negedge ref_clk);
      k++;
    end
    cmp_n("init delay", 2, k);
    k = 0;
    p = -1;
    while (s_init === 1'b1 && k < 999) begin
      if (pv === 1'b1 && p < 0) p = k;
      @(negedge ref_clk);
      k++;
    end
    cmp_n("init len", t ? 256 : 128, k);
    cmp_n("idle len", t ? 16 : 8, p);
    cmp_v("block state", 8'h01, {7'h00, s_blk});
    cmp_v("selects", {6'h00, t, r}, {6'h00, t_r, r_r});
    cmp_v("first block ref", t ? 8'h3c : 8'hbc, p_ref);
    k = 0;
    while (done !== 1'b1 && k < 999) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    k = 1;
    while (done !== 1'b1 && k < 999) begin
      @(negedge ref_clk);
      k++;
    end
    blen = (t ? 64 : 32) * ((n == 4'h0) ? 1 : int'(n));
    cmp_n("block len", blen, k);
    cmp_v("ref pix", 8'(8'h3c + (t ? 256 : 128) + 2 * blen - 1), p_ref);
    cmp_v("win a", ti ? u_c : u_a, p_a);
    cmp_v("win b", u_b, p_b);
    cmp_v("win c", u_c, p_c);
    cmp_v("busy", 8'h01, {7'h00, busy});
    cmp_v("sync error", 8'h00, {7'h00, se});
  endtask

  initial begin
    run_case(1'b0, 1'b1, 4'h2, 1'b0);
    run_case(1'b1, 1'b1, 4'h1, 1'b1);
    run_case(1'b0, 1'b0, 4'h3, 1'b0);
    run_case(1'b1, 1'b0, 4'h0, 1'b0);
    final_report();
  end
endmodule
